/* File: src/lsf_pkg.sv */
// constants, field layout and carrier types of the line status flag block
package lsf_pkg;

    // data width and default queue depths
    localparam int DATA_W     = 8;
    localparam int RX_DEPTH   = 16;
    localparam int TX_DEPTH   = 16;

    // byte offsets on the register bus
    localparam logic [5:0] OFS_DATA       = 6'h00;
    localparam logic [5:0] OFS_LINE_STAT  = 6'h04;
    localparam logic [5:0] OFS_CONTROL    = 6'h08;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h0C;
    localparam logic [5:0] OFS_IRQ_ENABLE = 6'h10;
    localparam logic [5:0] OFS_IRQ_CLEAR  = 6'h14;

    // serial_line_status bit positions
    localparam int LS_DATA_READY = 0;
    localparam int LS_OVERRUN    = 1;
    localparam int LS_PARITY     = 2;
    localparam int LS_FRAMING    = 3;
    localparam int LS_BREAK      = 4;
    localparam int LS_THR_EMPTY  = 5;
    localparam int LS_TX_EMPTY   = 6;
    localparam int LS_FIFO_ERR   = 7;

    // control register fields and reset values
    localparam int         CTRL_FIFO_MODE  = 0;
    localparam logic       FIFO_MODE_RESET = 1'b0;

    // interrupt status, enable and clear layout
    localparam int         IRQ_W           = 3;
    localparam int         IRQ_THR_EMPTY   = 0;
    localparam int         IRQ_RX_READY    = 1;
    localparam int         IRQ_LINE_ERR    = 2;
    localparam logic [2:0] IRQ_EN_RESET    = 3'h0;

    // break detection: one character frame at the default line rate
    localparam int CLK_PERIOD_NS = 10;
    localparam int FRAME_TIME_NS = 86800;
    localparam int BREAK_CYCLES  = (FRAME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // one received character with its error marks
    typedef struct packed {
        logic              brk;
        logic              frame_err;
        logic              parity_err;
        logic [DATA_W-1:0] data;
    } lsf_rx_char_t;

    function automatic logic has_error(input lsf_rx_char_t c);
        return c.brk | c.frame_err | c.parity_err;
    endfunction

endpackage

/* File: src/lsf_rx_fifo.sv */
// receive queue holding characters with per-entry error marks
`timescale 1ns/1ps
`default_nettype none
module lsf_rx_fifo #(
    parameter int DEPTH = lsf_pkg::RX_DEPTH,
    parameter int CW    = $clog2(DEPTH + 1),
    parameter int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    // fill side
    input  wire logic                 push_in,
    input  wire lsf_pkg::lsf_rx_char_t push_char_in,
    input  wire logic [CW-1:0]        limit_in,
    // drain side
    input  wire logic                 pop_in,
    output lsf_pkg::lsf_rx_char_t     head_out,
    // state
    output logic                      full_out,
    output logic                      empty_out,
    output logic                      err_any_out,
    output logic [CW-1:0]             count_out
);

    lsf_pkg::lsf_rx_char_t mem      [DEPTH];
    lsf_pkg::lsf_rx_char_t next_mem [DEPTH];
    logic [AW-1:0]         wr_ptr;
    logic [AW-1:0]         rd_ptr;
    logic [CW-1:0]         count;
    logic [CW-1:0]         err_count;
    logic [AW-1:0]         next_wr_ptr;
    logic [AW-1:0]         next_rd_ptr;
    logic [CW-1:0]         next_count;
    logic [CW-1:0]         next_err_count;
    logic                  do_push;
    logic                  do_pop;

    function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    assign full_out    = (count >= limit_in);
    assign empty_out   = (count == '0);
    assign err_any_out = (err_count != '0);
    assign count_out   = count;
    assign head_out    = mem[rd_ptr];
    assign do_push     = push_in && !full_out;
    assign do_pop      = pop_in && !empty_out;

    always_comb
    begin
        next_mem       = mem;
        next_wr_ptr    = wr_ptr;
        next_rd_ptr    = rd_ptr;
        next_count     = count;
        next_err_count = err_count;
        if (do_push)
        begin
            next_mem[wr_ptr] = push_char_in;
            next_wr_ptr      = wrap(wr_ptr);
        end
        if (do_pop)
            next_rd_ptr = wrap(rd_ptr);
        if (do_push && !do_pop)
            next_count = count + CW'(1);
        else if (!do_push && do_pop)
            next_count = count - CW'(1);
        // errored entries are counted so the summary drops only when none remain
        if ((do_push && lsf_pkg::has_error(push_char_in)) && !(do_pop && lsf_pkg::has_error(head_out)))
            next_err_count = err_count + CW'(1);
        else if (!(do_push && lsf_pkg::has_error(push_char_in)) && (do_pop && lsf_pkg::has_error(head_out)))
            next_err_count = err_count - CW'(1);
    end

    always_ff @(posedge clk_in)
    begin
        mem <= next_mem;
        if (reset_in)
        begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            err_count <= '0;
        end
        else
        begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            err_count <= next_err_count;
        end
    end

endmodule
`default_nettype wire

/* File: src/lsf_top.sv */
// line status flags of one serial channel with its Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module lsf_top #(
    parameter int RX_DEPTH     = lsf_pkg::RX_DEPTH,
    parameter int TX_DEPTH     = lsf_pkg::TX_DEPTH,
    parameter int BREAK_CYCLES = lsf_pkg::BREAK_CYCLES
) (
    // clock and reset
    input  wire logic                  CORE_CLK_IN,
    input  wire logic                  RESET_IN,
    // wishbone slave
    input  wire logic                  WB_CYC_IN,
    input  wire logic                  WB_STB_IN,
    input  wire logic                  WB_WE_IN,
    input  wire logic [5:0]            WB_ADR_IN,
    input  wire logic [3:0]            WB_SEL_IN,
    input  wire logic [31:0]           WB_DAT_IN,
    output logic [31:0]                WB_DAT_OUT,
    output logic                       WB_ACK_OUT,
    // receiver side
    input  wire logic                  RX_SERIAL_IN,
    input  wire logic                  RX_CHAR_VALID_IN,
    input  wire lsf_pkg::lsf_rx_char_t RX_CHAR_IN,
    // transmit shifter side
    output logic [7:0]                 TX_DATA_OUT,
    output logic                       TX_VALID_OUT,
    input  wire logic                  TX_TAKE_IN,
    input  wire logic                  TSR_BUSY_IN,
    // interrupt
    output logic                       IRQ_OUT
);

    localparam int RCW = $clog2(RX_DEPTH + 1);
    localparam int TCW = $clog2(TX_DEPTH + 1);
    localparam int TAW = (TX_DEPTH > 1) ? $clog2(TX_DEPTH) : 1;
    localparam int BW  = $clog2(BREAK_CYCLES + 1);

    typedef enum logic [2:0] {
        BRK_IDLE  = 3'b001,
        BRK_COUNT = 3'b010,
        BRK_HELD  = 3'b100
    } lsf_brk_state_t;

    // bus decode
    logic        ack;
    logic [31:0] rd_data;
    logic        next_ack;
    logic [31:0] next_rd_data;
    logic        take;
    logic        wr_take;
    logic        rd_take;
    logic [7:0]  line_status;

    // control, overrun and interrupt state
    logic                    fifo_mode;
    logic [lsf_pkg::IRQ_W-1:0] irq_en;
    logic [lsf_pkg::IRQ_W-1:0] irq_status;
    logic                    irq;
    logic                    overrun;
    logic                    next_fifo_mode;
    logic [lsf_pkg::IRQ_W-1:0] next_irq_en;
    logic [lsf_pkg::IRQ_W-1:0] next_irq_status;
    logic                    next_irq;
    logic                    next_overrun;

    // transmit queue
    logic [7:0]     tx_mem      [TX_DEPTH];
    logic [7:0]     next_tx_mem [TX_DEPTH];
    logic [TAW-1:0] tx_wr;
    logic [TAW-1:0] tx_rd;
    logic [TCW-1:0] tx_count;
    logic [TAW-1:0] next_tx_wr;
    logic [TAW-1:0] next_tx_rd;
    logic [TCW-1:0] next_tx_count;
    logic           tx_push;
    logic           tx_pop;

    // receive path and break detection
    logic                  rx_meta;
    logic                  rx_line;
    lsf_brk_state_t        brk_state;
    lsf_brk_state_t        next_brk_state;
    logic [BW-1:0]         brk_count;
    logic [BW-1:0]         next_brk_count;
    logic                  brk_push;
    logic                  rx_push;
    lsf_pkg::lsf_rx_char_t rx_push_char;
    lsf_pkg::lsf_rx_char_t rx_head;
    logic                  rx_full;
    logic                  rx_empty;
    logic                  rx_err_any;
    logic [RCW-1:0]        rx_count;
    logic                  rx_pop;

    function automatic logic [TAW-1:0] tx_wrap(input logic [TAW-1:0] p);
        return (p == TAW'(TX_DEPTH - 1)) ? '0 : p + TAW'(1);
    endfunction

    assign take    = WB_CYC_IN && WB_STB_IN && !ack;
    assign wr_take = take && WB_WE_IN && WB_SEL_IN[0];
    assign rd_take = take && !WB_WE_IN;

    // line status assembled from live queue and shifter state, except the overrun bit, which is the registered sticky flag
    always_comb
    begin
        line_status                         = 8'h00;
        line_status[lsf_pkg::LS_FIFO_ERR]   = rx_err_any;
        line_status[lsf_pkg::LS_TX_EMPTY]   = (tx_count == '0) && !TSR_BUSY_IN;
        line_status[lsf_pkg::LS_THR_EMPTY]  = (tx_count == '0);
        line_status[lsf_pkg::LS_BREAK]      = !rx_empty && rx_head.brk;
        line_status[lsf_pkg::LS_FRAMING]    = !rx_empty && rx_head.frame_err;
        line_status[lsf_pkg::LS_PARITY]     = !rx_empty && rx_head.parity_err;
        line_status[lsf_pkg::LS_OVERRUN]    = overrun;
        line_status[lsf_pkg::LS_DATA_READY] = !rx_empty;
    end

    // bus answer: ack registered one cycle after the request, unmapped reads give zero
    always_comb
    begin
        next_ack     = WB_CYC_IN && WB_STB_IN && !ack;
        next_rd_data = 32'h0000_0000;
        if (rd_take)
        begin
            unique case (WB_ADR_IN)
                lsf_pkg::OFS_DATA:       next_rd_data = {24'h00_0000, rx_head.data};
                lsf_pkg::OFS_LINE_STAT:  next_rd_data = {24'h00_0000, line_status};
                lsf_pkg::OFS_CONTROL:    next_rd_data = {31'h0000_0000, fifo_mode};
                lsf_pkg::OFS_IRQ_STATUS: next_rd_data = {29'h0000_0000, irq_status};
                lsf_pkg::OFS_IRQ_ENABLE: next_rd_data = {29'h0000_0000, irq_en};
                default:                 next_rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            ack     <= 1'b0;
            rd_data <= 32'h0000_0000;
        end
        else
        begin
            ack     <= next_ack;
            rd_data <= next_rd_data;
        end
    end

    assign WB_ACK_OUT = ack;
    assign WB_DAT_OUT = rd_data;

    // control, overrun and interrupt; hardware sets win over clears
    always_comb
    begin
        next_fifo_mode  = fifo_mode;
        next_irq_en     = irq_en;
        next_irq_status = irq_status;
        next_overrun    = overrun;
        if (wr_take && WB_ADR_IN == lsf_pkg::OFS_CONTROL)
            next_fifo_mode = WB_DAT_IN[lsf_pkg::CTRL_FIFO_MODE];
        if (wr_take && WB_ADR_IN == lsf_pkg::OFS_IRQ_ENABLE)
            next_irq_en = WB_DAT_IN[lsf_pkg::IRQ_W-1:0];
        if (wr_take && WB_ADR_IN == lsf_pkg::OFS_IRQ_CLEAR)
            next_irq_status = irq_status & ~WB_DAT_IN[lsf_pkg::IRQ_W-1:0];
        // overrun clears on a status read, never on a write to it
        if (rd_take && WB_ADR_IN == lsf_pkg::OFS_LINE_STAT)
            next_overrun = 1'b0;
        if (rx_push && rx_full)
            next_overrun = 1'b1;
        if (line_status[lsf_pkg::LS_THR_EMPTY])
            next_irq_status[lsf_pkg::IRQ_THR_EMPTY] = 1'b1;
        if (rx_push && !rx_full)
            next_irq_status[lsf_pkg::IRQ_RX_READY] = 1'b1;
        if ((rx_push && rx_full) || (rx_push && lsf_pkg::has_error(rx_push_char)))
            next_irq_status[lsf_pkg::IRQ_LINE_ERR] = 1'b1;
        next_irq = |(next_irq_status & next_irq_en);
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            fifo_mode  <= lsf_pkg::FIFO_MODE_RESET;
            irq_en     <= lsf_pkg::IRQ_EN_RESET;
            irq_status <= '0;
            irq        <= 1'b0;
            overrun    <= 1'b0;
        end
        else
        begin
            fifo_mode  <= next_fifo_mode;
            irq_en     <= next_irq_en;
            irq_status <= next_irq_status;
            irq        <= next_irq;
            overrun    <= next_overrun;
        end
    end

    assign IRQ_OUT = irq;

    // transmit queue: one entry deep outside fifo mode, acting as holding register
    assign tx_push      = wr_take && (WB_ADR_IN == lsf_pkg::OFS_DATA)
                          && (tx_count < (fifo_mode ? TCW'(TX_DEPTH) : TCW'(1)));
    assign TX_VALID_OUT = (tx_count != '0);
    assign TX_DATA_OUT  = tx_mem[tx_rd];
    assign tx_pop       = TX_TAKE_IN && TX_VALID_OUT;

    always_comb
    begin
        next_tx_mem   = tx_mem;
        next_tx_wr    = tx_wr;
        next_tx_rd    = tx_rd;
        next_tx_count = tx_count;
        if (tx_push)
        begin
            next_tx_mem[tx_wr] = WB_DAT_IN[7:0];
            next_tx_wr         = tx_wrap(tx_wr);
        end
        if (tx_pop)
            next_tx_rd = tx_wrap(tx_rd);
        if (tx_push && !tx_pop)
            next_tx_count = tx_count + TCW'(1);
        else if (!tx_push && tx_pop)
            next_tx_count = tx_count - TCW'(1);
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        tx_mem <= next_tx_mem;
        if (RESET_IN)
        begin
            tx_wr    <= '0;
            tx_rd    <= '0;
            tx_count <= '0;
        end
        else
        begin
            tx_wr    <= next_tx_wr;
            tx_rd    <= next_tx_rd;
            tx_count <= next_tx_count;
        end
    end

    // serial input synchroniser
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            rx_meta <= 1'b1;
            rx_line <= 1'b1;
        end
        else
        begin
            rx_meta <= RX_SERIAL_IN;
            rx_line <= rx_meta;
        end
    end

    // break detector: count a full frame of low line, then wait for idle
    always_comb
    begin
        next_brk_state = brk_state;
        next_brk_count = brk_count;
        brk_push       = 1'b0;
        unique case (brk_state)
            BRK_IDLE:
            begin
                next_brk_count = BW'(1);
                if (!rx_line)
                    next_brk_state = BRK_COUNT;
            end
            BRK_COUNT:
            begin
                next_brk_count = brk_count + BW'(1);
                if (rx_line)
                    next_brk_state = BRK_IDLE;
                else if (brk_count == BW'(BREAK_CYCLES - 1))
                begin
                    brk_push       = 1'b1;
                    next_brk_state = BRK_HELD;
                end
            end
            BRK_HELD:
            begin
                if (rx_line)
                    next_brk_state = BRK_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            brk_state <= BRK_IDLE;
            brk_count <= '0;
        end
        else
        begin
            brk_state <= next_brk_state;
            brk_count <= next_brk_count;
        end
    end

    // the break character takes the queue slot over a same-cycle receiver character
    assign rx_push      = brk_push || RX_CHAR_VALID_IN;
    assign rx_push_char = brk_push ? lsf_pkg::lsf_rx_char_t'{brk: 1'b1, frame_err: 1'b0,
                                                             parity_err: 1'b0, data: 8'h00}
                                   : RX_CHAR_IN;
    assign rx_pop       = rd_take && (WB_ADR_IN == lsf_pkg::OFS_DATA);

    lsf_rx_fifo #(
        .DEPTH        (RX_DEPTH)
    ) u_rx_fifo (
        .clk_in       (CORE_CLK_IN),
        .reset_in     (RESET_IN),
        .push_in      (rx_push),
        .push_char_in (rx_push_char),
        .limit_in     (fifo_mode ? RCW'(RX_DEPTH) : RCW'(1)),
        .pop_in       (rx_pop),
        .head_out     (rx_head),
        .full_out     (rx_full),
        .empty_out    (rx_empty),
        .err_any_out  (rx_err_any),
        .count_out    (rx_count)
    );

    a_err_summary_set: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (rx_push && !rx_full && lsf_pkg::has_error(rx_push_char)) |=> line_status[lsf_pkg::LS_FIFO_ERR])
        else $error("error summary not set after errored character");
    a_err_summary_empty: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        rx_empty |-> !line_status[lsf_pkg::LS_FIFO_ERR])
        else $error("error summary set with empty receive queue");
    a_tx_empty_set: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (tx_pop && tx_count == TCW'(1) && !tx_push) ##1 !TSR_BUSY_IN |-> line_status[lsf_pkg::LS_TX_EMPTY])
        else $error("transmit empty not set with nothing queued");
    a_tx_empty_clear: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        tx_push |=> !line_status[lsf_pkg::LS_TX_EMPTY])
        else $error("transmit empty still set after write");
    a_holding_clear: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        tx_push |=> !line_status[lsf_pkg::LS_THR_EMPTY]
                    && (tx_count == $past(tx_count) + TCW'(1) - TCW'($past(tx_pop))))
        else $error("holding empty not cleared by write");
    a_holding_set: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (tx_pop && tx_count == TCW'(1) && !tx_push) |=> line_status[lsf_pkg::LS_THR_EMPTY])
        else $error("holding empty not set after last character moved");
    a_holding_irq: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (line_status[lsf_pkg::LS_THR_EMPTY] && next_irq_en[lsf_pkg::IRQ_THR_EMPTY]) |=> IRQ_OUT)
        else $error("holding empty interrupt missing");
    a_break_once: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        brk_push |=> !brk_push [*8])
        else $error("second break character in one condition");
    a_break_low_line: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        brk_push |-> !rx_line && !$past(rx_line) && brk_state == BRK_COUNT)
        else $error("break pushed without low line");
    a_overrun_keep: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (rx_push && rx_full && !rx_pop) |=> overrun && $stable(rx_count))
        else $error("overrun not flagged or queue disturbed");
    a_status_write: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (wr_take && WB_ADR_IN == lsf_pkg::OFS_LINE_STAT && overrun) |=> overrun)
        else $error("status write altered overrun");
    a_head_framing: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (rx_push && !rx_full && rx_empty && !rx_pop) |=> line_status[lsf_pkg::LS_FRAMING] == $past(rx_push_char.frame_err))
        else $error("framing flag does not follow head character");

endmodule
`default_nettype wire

/* File: test/lsf_host.sv */
// host cpu model issuing classic wishbone single cycles
`timescale 1ns/1ps
`default_nettype none
module lsf_host (
    // bus answer
    input  wire logic        clk_in,
    input  wire logic        ack_in,
    input  wire logic [31:0] rdat_in,
    // bus request
    output logic             cyc_out,
    output logic             stb_out,
    output logic             we_out,
    output logic [5:0]       adr_out,
    output logic [3:0]       sel_out,
    output logic [31:0]      wdat_out,
    // wait ran out
    output logic             tout_out
);
    initial {cyc_out, stb_out, we_out, tout_out} = '0;
    initial {adr_out, sel_out, wdat_out} = '0;

    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_in);
        {cyc_out, stb_out, we_out} <= {2'b11, w};
        adr_out  <= a;
        sel_out  <= 4'hF;
        wdat_out <= d;
        do
            @(posedge clk_in) n++;
        while (ack_in !== 1'b1 && n < 64);
        q = rdat_in;
        if (n >= 64)
            tout_out = 1'b1;
        {cyc_out, stb_out, we_out} <= 3'h0;
        // released lines must not keep the old value
        adr_out  <= ~a;
        wdat_out <= ~d;
    endtask
endmodule
`default_nettype wire

/* File: test/test_lsf_top.sv */
// self-checking bench of the line status flag block
`timescale 1ns/1ps
`default_nettype none
module test_lsf_top;
    logic clk, rst, rxs, rxv, take, busy, cyc, stb, we, ack, txv, irq, tout, fm, ovr;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] wdi, wdo, q;
    logic [7:0] txd, b;
    logic [7:0] txq[$];
    lsf_pkg::lsf_rx_char_t rxc;
    logic [10:0] rxq[$];
    int seed = 23172, mismatches = 0, num_checks = 0, txn = 0;

    initial clk = 1'b0;
    initial forever #5 clk = ~clk;

    lsf_host host_u (.clk_in(clk), .ack_in(ack), .rdat_in(wdo), .cyc_out(cyc), .stb_out(stb), .we_out(we),
                     .adr_out(adr), .sel_out(sel), .wdat_out(wdi), .tout_out(tout));
    lsf_top #(.BREAK_CYCLES(20)) dut_u (.CORE_CLK_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdi), .WB_DAT_OUT(wdo), .WB_ACK_OUT(ack),
        .RX_SERIAL_IN(rxs), .RX_CHAR_VALID_IN(rxv), .RX_CHAR_IN(rxc), .TX_DATA_OUT(txd), .TX_VALID_OUT(txv),
        .TX_TAKE_IN(take), .TSR_BUSY_IN(busy), .IRQ_OUT(irq));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
        host_u.xfer(w, a, d, r);
        if (tout === 1'b1)
        begin
            mismatches++;
            stop_test();
        end
        if (w && a == 6'h00)
        begin
            txn++;
            txq.push_back(d[7:0]);
        end
        if (w && a == 6'h08)
            fm = d[0];
    endtask

    // expected status from the queue model
    function automatic logic [7:0] st();
        logic [7:0] s;
        s = 8'h00;
        if (rxq.size() > 0)
            s[4:0] = {rxq[0][10:8], 2'b01};
        foreach (rxq[i])
            if (rxq[i][10:8] != 3'h0)
                s[7] = 1'b1;
        s[1] = ovr;
        s[5] = (txn == 0);
        s[6] = (txn == 0) && !busy;
        return s;
    endfunction

    task automatic cs();
        logic [7:0] e;
        logic [31:0] r;
        bus(1'b0, 6'h04, 32'h0, r);
        e = st();
        chk(r, 32'(e));
        ovr = 1'b0;
    endtask

    task automatic rp(input logic [2:0] e);
        logic [10:0] c;
        c = {e, 8'($random(seed))};
        @(posedge clk);
        rxv <= 1'b1;
        rxc <= c;
        @(posedge clk);
        rxv <= 1'b0;
        if (rxq.size() < (fm ? 16 : 1))
            rxq.push_back(c);
        else
            ovr = 1'b1;
    endtask

    task automatic pop();
        logic [31:0] r;
        bus(1'b0, 6'h00, 32'h0, r);
        chk(32'(r[7:0]), 32'(rxq[0][7:0]));
        void'(rxq.pop_front());
    endtask

    task automatic tk();
        @(posedge clk);
        chk(32'(txv), 32'h1);
        chk(32'(txd), 32'(txq[0]));
        take <= 1'b1;
        busy <= 1'b1;
        @(posedge clk);
        take <= 1'b0;
        txn--;
        void'(txq.pop_front());
    endtask

    initial
    begin
        {rst, rxs, rxv, take, busy, fm, ovr} = 7'b1100000;
        rxc = '0;
        wt(16);
        rst <= 1'b0;
        cs();
        bus(1'b0, 6'h3C, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b1, 6'h04, $random(seed), q);
        cs();
        bus(1'b1, 6'h10, 32'h1, q);
        wt(2);
        chk(32'(irq), 32'h1);
        b = 8'($random(seed));
        bus(1'b1, 6'h00, 32'(b), q);
        cs();
        chk(32'(txd), 32'(b));
        bus(1'b1, 6'h14, 32'h1, q);
        wt(2);
        chk(32'(irq), 32'h0);
        tk();
        cs();
        chk(32'(irq), 32'h1);
        busy <= 1'b0;
        cs();
        bus(1'b1, 6'h10, 32'h0, q);
        wt(2);
        chk(32'(irq), 32'h0);
        rp(3'h0);
        rp(3'h0);
        bus(1'b1, 6'h04, 32'hFF, q);
        cs();
        bus(1'b0, 6'h0C, 32'h0, q);
        chk(q, 32'h7);
        bus(1'b1, 6'h14, 32'h6, q);
        bus(1'b0, 6'h0C, 32'h0, q);
        chk(q, 32'h1);
        pop();
        cs();
        bus(1'b1, 6'h08, 32'h1, q);
        repeat (3) bus(1'b1, 6'h00, $random(seed), q);
        cs();
        repeat (3) tk();
        cs();
        chk(32'(txv), 32'h0);
        busy <= 1'b0;
        cs();
        rp(3'h0);
        rp(3'h1);
        rp(3'h2);
        rp(3'h0);
        cs();
        repeat (4)
        begin
            pop();
            cs();
        end
        rxs <= 1'b0;
        wt(60);
        rxs <= 1'b1;
        wt(5);
        rxq.push_back(11'h400);
        cs();
        pop();
        rp(3'h0);
        cs();
        pop();
        cs();
        stop_test();
    end
endmodule
`default_nettype wire
